// ### src/hpc_pkg.sv
// Purpose: shared constants and carrier types for the host port control block
// Assumes: 8-bit host bus, 16-bit shared memory words, 10 MHz system clock
// Notes:   control bits are mirrored in both halves of the control register
package hpc_pkg;

  // ==========================================================================
  // register select encodings
  // ==========================================================================
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_DATA_AI = 2'h1;
  localparam logic [1:0] SEL_ADDRESS = 2'h2;
  localparam logic [1:0] SEL_DATA    = 2'h3;

  // ==========================================================================
  // control register fields (low half, mirrored at +8)
  // ==========================================================================
  localparam int          BIT_BYTE_ORDER  = 0;
  localparam int          BIT_ACCESS_MODE = 1;
  localparam int          BIT_CORE_INT    = 2;
  localparam int          BIT_HOST_INT    = 3;
  localparam int          HALF_SHIFT      = 8;
  localparam logic [15:0] CONTROL_RESET   = 16'h0000;

  // ==========================================================================
  // memory and timing
  // ==========================================================================
  localparam int          MEM_ADDR_W      = 11;
  localparam int          MEM_DATA_W      = 16;
  localparam int          SYNC_STAGES     = 3;
  localparam int          BUF_DEPTH       = 2;

  // one host request after strobe qualification
  typedef struct packed {
    logic [1:0] sel;
    logic       rd;
    logic       second;
    logic [7:0] data;
  } host_req_t;

  // posted memory write
  typedef struct packed {
    logic [MEM_ADDR_W-1:0] addr;
    logic [MEM_DATA_W-1:0] data;
  } mem_wr_t;

endpackage

// ### src/hpc_post_buffer.sv
// Purpose: two-entry valid/ready buffer for posted memory writes
// Assumes: single clock, source holds data while valid and not ready
// Notes:   full drops in_ready_o, stalling the host port via ready in shared access mode
module hpc_post_buffer
  import hpc_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic    clk_sys_i,
  input  wire logic    rst_n_i,
  input  wire logic    in_valid_i,
  input  wire mem_wr_t in_data_i,
  output logic         in_ready_o,
  output logic         out_valid_o,
  input  wire logic    out_ready_i,
  output mem_wr_t      out_data_o
);

  // refuse depths that the single-bit pointers cannot serve
  if (DEPTH != 2) begin : g_bad_depth
    $error("buffer supports depth 2 only");
  end

  mem_wr_t    slot_reg [DEPTH];
  logic       wptr_reg;
  logic       rptr_reg;
  logic [1:0] count_reg;
  logic       push;
  logic       pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o  = slot_reg[rptr_reg];

  // storage
  always_ff @(posedge clk_sys_i) begin
    if (push) slot_reg[wptr_reg] <= in_data_i;
  end

  // pointers and occupancy
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_reg  <= 1'b0;
      rptr_reg  <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) wptr_reg <= ~wptr_reg;
      if (pop)  rptr_reg <= ~rptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// ### src/hpc_host_port.sv
// Purpose: 8-bit host port with control, address and data registers
// Assumes: host strobes are asynchronous; shared memory is 2K x 16 here
// Notes:   memory writes are posted through a two-entry buffer
//
// Operation
// - reserved control bits read as zero
// - host flag set by core, cleared by host
// - writing zero leaves host flag alone
// - host one on request interrupts the core
// - core interrupt request always reads zero
// - every host one makes a new interrupt
// - mode bit core-writable, host-only mode at reset
// - byte order bit host-only, selects first byte
// - read post-increments, write pre-increments address
// - memory uses 11 address bits, counter 16
// - no interrupt writes while changing other bits
// - sample selects when last strobe goes active
// - ready output inserts wait states
// - address or data write launches transfer
// - read returns prefetched word, writes post later
// - read after write returns written value
// - wait states only in shared access mode
// - ready high off-select and for fast accesses
// - selects: control, data-inc, address, data
module hpc_host_port
  import hpc_pkg::*;
#(
  parameter int MEM_WORDS = 2048
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // host pins
  input  wire logic       port_chip_select_n_i,
  input  wire logic       data_strobe_one_n_i,
  input  wire logic       data_strobe_two_n_i,
  input  wire logic       read_write_select_i,
  input  wire logic       register_select_high_i,
  input  wire logic       register_select_low_i,
  input  wire logic       half_word_select_i,
  input  wire logic [7:0] host_data_i,
  output logic      [7:0] host_data_o,
  output logic            host_data_oe_o,
  output logic            port_ready_o,
  output logic            host_interrupt_o,
  // core side
  input  wire logic       core_ctrl_wr_i,
  input  wire logic [15:0] core_ctrl_wdata_i,
  output logic      [15:0] core_ctrl_rdata_o,
  output logic            core_interrupt_o
);

  if (MEM_WORDS != (1 << MEM_ADDR_W)) begin : g_bad_size
    $error("memory size must match address width");
  end

  // ==========================================================================
  // strobe synchronisation
  // ==========================================================================
  logic [SYNC_STAGES-1:0] stb_sync_reg;
  logic                   stb_prev_reg;
  logic                   strobe_raw;
  logic                   strobe_on;
  logic                   strobe_rise;
  logic                   strobe_fall;

  // internal strobe: active only when all three are low, so the last one times it
  assign strobe_raw = !port_chip_select_n_i && !data_strobe_one_n_i
                      && !data_strobe_two_n_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stb_sync_reg <= '0;
      stb_prev_reg <= 1'b0;
    end else begin
      stb_sync_reg <= {stb_sync_reg[SYNC_STAGES-2:0], strobe_raw};
      if (stb_sync_reg[1] == stb_sync_reg[2]) stb_prev_reg <= stb_sync_reg[2];
    end
  end

  assign strobe_on   = (stb_sync_reg[1] == stb_sync_reg[2]) ? stb_sync_reg[2] : stb_prev_reg;
  assign strobe_rise = strobe_on && !stb_prev_reg;
  assign strobe_fall = !strobe_on && stb_prev_reg;

  // ==========================================================================
  // request capture (selects sampled at the internal strobe)
  // ==========================================================================
  host_req_t req_reg;
  logic      cycle_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_reg   <= '0;
      cycle_reg <= 1'b0;
    end else begin
      if (strobe_rise) begin
        req_reg.sel    <= {register_select_high_i, register_select_low_i};
        req_reg.rd     <= read_write_select_i;
        req_reg.second <= half_word_select_i;
        req_reg.data   <= host_data_i;
        cycle_reg      <= 1'b1;
      end else if (strobe_fall) begin
        cycle_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  logic        host_interrupt_flag_reg;
  logic        access_mode_select_reg;
  logic        byte_order_select_reg;
  logic        core_interrupt_reg;
  logic [15:0] port_address_register_reg;
  logic [15:0] port_data_register_reg;
  logic [7:0]  first_byte_reg;
  logic [15:0] word;
  logic        host_wr_end;
  logic        ctrl_host_wr;
  logic        addr_host_wr;
  logic        data_host_wr;
  logic        data_host_rd;
  logic        data_auto_inc;
  logic        core_set_host_interrupt_flag;
  logic        core_set_host_interrupt_flag_lo;
  logic        host_clr_host_interrupt_flag;

  // a write completes on the second byte, when the host strobe ends
  assign host_wr_end   = strobe_fall && !req_reg.rd && req_reg.second;
  assign ctrl_host_wr  = host_wr_end && (req_reg.sel == SEL_CONTROL);
  assign addr_host_wr  = host_wr_end && (req_reg.sel == SEL_ADDRESS);
  assign data_host_wr  = host_wr_end && req_reg.sel[0];
  assign data_host_rd  = strobe_fall && req_reg.rd && req_reg.second && req_reg.sel[0];
  assign data_auto_inc = (req_reg.sel == SEL_DATA_AI);

  // assemble the 16-bit word in the chosen byte order
  assign word = byte_order_select_reg ? {req_reg.data, first_byte_reg}
                                      : {first_byte_reg, req_reg.data};

  assign core_set_host_interrupt_flag_lo = core_ctrl_wdata_i[BIT_HOST_INT];
  assign core_set_host_interrupt_flag    = core_ctrl_wr_i && (core_set_host_interrupt_flag_lo
                            || core_ctrl_wdata_i[BIT_HOST_INT+HALF_SHIFT]);
  assign host_clr_host_interrupt_flag    = ctrl_host_wr && req_reg.data[BIT_HOST_INT];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_byte_reg <= 8'h00;
    end else if (strobe_fall && !req_reg.rd && !req_reg.second) begin
      first_byte_reg <= req_reg.data;
    end
  end

  // host interrupt flag: core sets, host clears, zero writes ignored
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_interrupt_flag_reg <= CONTROL_RESET[BIT_HOST_INT];
    end else if (core_set_host_interrupt_flag) begin
      host_interrupt_flag_reg <= 1'b1;
    end else if (host_clr_host_interrupt_flag) begin
      host_interrupt_flag_reg <= 1'b0;
    end
  end

  // mode bit written only by the core; host-only mode out of reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      access_mode_select_reg <= CONTROL_RESET[BIT_ACCESS_MODE];
    end else if (core_ctrl_wr_i) begin
      access_mode_select_reg <= core_ctrl_wdata_i[BIT_ACCESS_MODE];
    end
  end

  // byte order written only by the host, from the second byte of the pair
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_order_select_reg <= CONTROL_RESET[BIT_BYTE_ORDER];
    end else if (ctrl_host_wr) begin
      byte_order_select_reg <= req_reg.data[BIT_BYTE_ORDER];
    end
  end

  // one-cycle core interrupt per host write of one
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_interrupt_reg <= 1'b0;
    end else begin
      core_interrupt_reg <= ctrl_host_wr && req_reg.data[BIT_CORE_INT];
    end
  end

  // ==========================================================================
  // shared memory, address counter, prefetch and posted writes
  // ==========================================================================
  logic [MEM_DATA_W-1:0] mem_arr [MEM_WORDS];
  mem_wr_t               post_in;
  mem_wr_t               post_out;
  logic                  post_ready;
  logic                  post_valid;
  logic                  post_push_reg;
  logic                  fetch_reg;
  logic [15:0]           addr_next;

  // pre-increment on auto-increment writes, post-increment after reads
  always_comb begin
    addr_next = port_address_register_reg;
    if (addr_host_wr) begin
      addr_next = word;
    end else if (data_host_wr && data_auto_inc) begin
      addr_next = port_address_register_reg + 16'h0001;
    end else if (data_host_rd && data_auto_inc) begin
      addr_next = port_address_register_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_address_register_reg <= 16'h0000;
    end else begin
      port_address_register_reg <= addr_next;
    end
  end

  // post the write after the host cycle; fetch after address write or read
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      post_push_reg <= 1'b0;
      fetch_reg     <= 1'b0;
    end else begin
      if (data_host_wr) post_push_reg <= 1'b1;
      else if (post_ready) post_push_reg <= 1'b0;
      fetch_reg <= addr_host_wr || data_host_rd;
    end
  end

  assign post_in.addr = port_address_register_reg[MEM_ADDR_W-1:0];
  assign post_in.data = port_data_register_reg;

  hpc_post_buffer #(
    .DEPTH(BUF_DEPTH)
  ) u_post (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .in_valid_i (post_push_reg),
    .in_data_i  (post_in),
    .in_ready_o (post_ready),
    .out_valid_o(post_valid),
    .out_ready_i(1'b1),
    .out_data_o (post_out)
  );

  always_ff @(posedge clk_sys_i) begin
    if (post_valid) mem_arr[post_out.addr] <= post_out.data;
  end

  // data register: holds written word, else prefetched word
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_data_register_reg <= 16'h0000;
    end else if (data_host_wr) begin
      port_data_register_reg <= word;
    end else if (fetch_reg && !post_push_reg && !post_valid) begin
      port_data_register_reg <= mem_arr[port_address_register_reg[MEM_ADDR_W-1:0]];
    end
  end

  // ==========================================================================
  // read data and ready
  // ==========================================================================
  logic [3:0]  ctrl_nibble;
  logic [15:0] host_word;
  logic [7:0]  host_byte;
  logic        busy;
  logic        fast_access;

  // core interrupt request reads zero; reserved fields zero
  assign ctrl_nibble = {host_interrupt_flag_reg, 1'b0, access_mode_select_reg,
                        byte_order_select_reg};

  always_comb begin
    unique case (req_reg.sel)
      SEL_CONTROL: host_word = {4'h0, ctrl_nibble, 4'h0, ctrl_nibble};
      SEL_ADDRESS: host_word = port_address_register_reg;
      SEL_DATA_AI,
      SEL_DATA:    host_word = port_data_register_reg;
    endcase
  end

  assign host_byte = (req_reg.second == byte_order_select_reg) ? host_word[15:8]
                                                               : host_word[7:0];

  // control/address reads and plain control writes never wait
  assign fast_access = (req_reg.sel == SEL_CONTROL && req_reg.rd)
                       || (req_reg.sel == SEL_ADDRESS && req_reg.rd)
                       || (req_reg.sel == SEL_CONTROL && !req_reg.rd
                           && !req_reg.data[BIT_CORE_INT]
                           && !req_reg.data[BIT_HOST_INT]);
  assign busy = post_push_reg || post_valid || fetch_reg || !post_ready;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_ready_o <= 1'b1;
    end else if (port_chip_select_n_i || !access_mode_select_reg) begin
      port_ready_o <= 1'b1;
    end else begin
      port_ready_o <= !(cycle_reg && busy && !fast_access);
    end
  end

  // host data, interrupt and core outputs, all registered
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_data_o       <= 8'h00;
      host_data_oe_o    <= 1'b0;
      host_interrupt_o  <= 1'b0;
      core_ctrl_rdata_o <= 16'h0000;
      core_interrupt_o  <= 1'b0;
    end else begin
      host_data_o       <= host_byte;
      host_data_oe_o    <= cycle_reg && req_reg.rd && strobe_on;
      host_interrupt_o  <= host_interrupt_flag_reg;
      core_ctrl_rdata_o <= {4'h0, host_interrupt_flag_reg, 1'b0, access_mode_select_reg, 1'b0,
                            4'h0, host_interrupt_flag_reg, 1'b0, access_mode_select_reg,
                            1'b0};
      core_interrupt_o  <= core_interrupt_reg;
    end
  end

endmodule

// ### sim/hpc_host_model.sv
// Purpose: host master driving the 8-bit port pins in byte pairs
// Assumes: pins move on falling edges, answers are taken on rising edges
// Notes:   released write data shows the inverse of the last byte
module hpc_host_model (
  input  wire logic       clk_sys_i,
  input  wire logic       port_ready_i,
  input  wire logic [7:0] host_data_i,
  output logic            port_chip_select_n_o,
  output logic            data_strobe_one_n_o,
  output logic            data_strobe_two_n_o,
  output logic            read_write_select_o,
  output logic            register_select_high_o,
  output logic            register_select_low_o,
  output logic            half_word_select_o,
  output logic      [7:0] host_data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========
  // idle pins
  // ==========
  initial begin
    {port_chip_select_n_o, data_strobe_one_n_o, data_strobe_two_n_o} = 3'h7;
    {read_write_select_o, register_select_high_o, register_select_low_o} = 3'h0;
    half_word_select_o = 1'b0;
    host_data_o        = 8'h00;
  end

  // ==========
  // byte cycle
  // ==========
  // selects settle with chip select, strobes go low one clock later
  task automatic xfer(input logic [1:0] sel, input logic rd, input logic half,
                      input logic [7:0] wb, output logic [7:0] rb);
    @(negedge clk_sys_i);
    {register_select_high_o, register_select_low_o} = sel;
    read_write_select_o  = rd;
    half_word_select_o   = half;
    host_data_o          = rd ? ~host_data_o : wb;
    port_chip_select_n_o = 1'b0;
    @(negedge clk_sys_i);
    {data_strobe_one_n_o, data_strobe_two_n_o} = 2'h0;
    repeat (5) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    // a port that never answers is caught by the bench watchdog
    while (port_ready_i !== 1'b1) begin
      @(posedge clk_sys_i);
    end
    rb = host_data_i;
    @(negedge clk_sys_i);
    {port_chip_select_n_o, data_strobe_one_n_o, data_strobe_two_n_o} = 3'h7;
    host_data_o = ~host_data_o;
    repeat (5) @(negedge clk_sys_i);
  endtask

  // a word is always a first/second byte pair, order from byte order
  task automatic wr16(input logic [1:0] sel, input logic [15:0] w, input logic bo);
    logic [7:0] unused;
    xfer(sel, 1'b0, 1'b0, bo ? w[7:0] : w[15:8], unused);
    xfer(sel, 1'b0, 1'b1, bo ? w[15:8] : w[7:0], unused);
    repeat (6) @(negedge clk_sys_i);
  endtask

  task automatic rd16(input logic [1:0] sel, input logic bo, output logic [15:0] w);
    logic [7:0] b1, b2;
    xfer(sel, 1'b1, 1'b0, 8'h00, b1);
    xfer(sel, 1'b1, 1'b1, 8'h00, b2);
    w = bo ? {b2, b1} : {b1, b2};
  endtask
endmodule

// ### sim/hpc_host_port_sva.sv
// Purpose: port-level checks for the host port control block
// Assumes: sees only the top module ports, one clock domain
// Notes:   idle spans of eight cycles cover the strobe synchroniser
module hpc_host_port_sva #(
  parameter int MEM_WORDS = 2048
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        port_chip_select_n_i,
  input wire logic        data_strobe_one_n_i,
  input wire logic        data_strobe_two_n_i,
  input wire logic        read_write_select_i,
  input wire logic        register_select_high_i,
  input wire logic        register_select_low_i,
  input wire logic        half_word_select_i,
  input wire logic [7:0]  host_data_i,
  input wire logic [7:0]  host_data_o,
  input wire logic        host_data_oe_o,
  input wire logic        port_ready_o,
  input wire logic        host_interrupt_o,
  input wire logic        core_ctrl_wr_i,
  input wire logic [15:0] core_ctrl_wdata_i,
  input wire logic [15:0] core_ctrl_rdata_o,
  input wire logic        core_interrupt_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // core write that sets the host flag, either half
  logic core_set;
  assign core_set = core_ctrl_wr_i & (core_ctrl_wdata_i[3] | core_ctrl_wdata_i[11]);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // ==========
  // checks
  // ==========
  a_ready_off_select: assert property (port_chip_select_n_i [*8] |-> port_ready_o)
    else $error("ready low while deselected");
  a_rdata_hidden_zero: assert property ((core_ctrl_rdata_o & 16'hF5F5) == 16'h0000)
    else $error("core view shows reserved, request or order bits");
  a_flag_set_core: assert property (core_set |-> ##[1:3] host_interrupt_o)
    else $error("core set of host flag not seen");
  a_flag_rise_cause: assert property ($rose(host_interrupt_o) |->
      $past(core_set, 1) || $past(core_set, 2) || $past(core_set, 3))
    else $error("host flag rose without core set");
  a_mode_core_write: assert property (core_ctrl_wr_i |-> ##2
      core_ctrl_rdata_o[1] == $past(core_ctrl_wdata_i[1], 2) &&
      core_ctrl_rdata_o[9] == $past(core_ctrl_wdata_i[1], 2))
    else $error("mode bit not taken from core write");
  a_mode_only_core: assert property ($changed(core_ctrl_rdata_o[1]) |->
      $past(core_ctrl_wr_i, 2))
    else $error("mode bit moved without core write");
  a_ready_host_only: assert property (!core_ctrl_rdata_o[1] && !$past(core_ctrl_rdata_o[1])
      |-> port_ready_o)
    else $error("wait state in host-only mode");
  a_core_int_idle: assert property (port_chip_select_n_i [*8] |-> !core_interrupt_o)
    else $error("core interrupt without host access");
  a_core_int_pulse: assert property (core_interrupt_o |=> !core_interrupt_o)
    else $error("core interrupt longer than one cycle");
  a_drive_idle: assert property (port_chip_select_n_i [*8] |-> !host_data_oe_o)
    else $error("data driven while deselected");
  a_drive_read_only: assert property (host_data_oe_o |-> read_write_select_i)
    else $error("data driven during a host write");

  c_core_int: cover property (core_interrupt_o);
  c_wait_state: cover property (!port_ready_o);
  c_read_drive: cover property (host_data_oe_o);
  c_flag_rise: cover property ($rose(host_interrupt_o));
endmodule

bind hpc_host_port hpc_host_port_sva #(.MEM_WORDS(MEM_WORDS)) u_sva (
  .clk_sys_i, .rst_n_i, .port_chip_select_n_i, .data_strobe_one_n_i,
  .data_strobe_two_n_i, .read_write_select_i, .register_select_high_i,
  .register_select_low_i, .half_word_select_i, .host_data_i, .host_data_o,
  .host_data_oe_o, .port_ready_o, .host_interrupt_o, .core_ctrl_wr_i,
  .core_ctrl_wdata_i, .core_ctrl_rdata_o, .core_interrupt_o
);

// ### sim/hpc_host_port_tb.sv
// Purpose: self-checking bench for the host port control block
// Assumes: host model drives the pins, core side is driven here
// Notes:   expected words are worked out from the written values
module hpc_host_port_tb
  import hpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        core_ctrl_wr_i = 1'b0;
  logic [15:0] core_ctrl_wdata_i = 16'h0000;
  logic        bo = 1'b0;
  logic        port_chip_select_n_i, data_strobe_one_n_i, data_strobe_two_n_i;
  logic        read_write_select_i, register_select_high_i, register_select_low_i;
  logic        half_word_select_i, host_data_oe_o, port_ready_o;
  logic        host_interrupt_o, core_interrupt_o;
  logic [7:0]  host_data_i, host_data_o;
  logic [15:0] core_ctrl_rdata_o;
  logic [15:0] n_core_int = 16'h0000;
  int          n_tests = 0;
  int          n_mismatch = 0;

  // ==========
  // clock, parts
  // ==========
  initial begin
    forever #50ns clk_sys_i = ~clk_sys_i;
  end

  hpc_host_model u_host (
    .clk_sys_i, .port_ready_i(port_ready_o), .host_data_i(host_data_o),
    .port_chip_select_n_o(port_chip_select_n_i), .data_strobe_one_n_o(data_strobe_one_n_i),
    .data_strobe_two_n_o(data_strobe_two_n_i), .read_write_select_o(read_write_select_i),
    .register_select_high_o(register_select_high_i),
    .register_select_low_o(register_select_low_i),
    .half_word_select_o(half_word_select_i), .host_data_o(host_data_i)
  );

  hpc_host_port #(.MEM_WORDS(2048)) dut (
    .clk_sys_i, .rst_n_i, .port_chip_select_n_i, .data_strobe_one_n_i,
    .data_strobe_two_n_i, .read_write_select_i, .register_select_high_i,
    .register_select_low_i, .half_word_select_i, .host_data_i, .host_data_o,
    .host_data_oe_o, .port_ready_o, .host_interrupt_o, .core_ctrl_wr_i,
    .core_ctrl_wdata_i, .core_ctrl_rdata_o, .core_interrupt_o
  );

  // counts core interrupt pulses
  always @(posedge clk_sys_i) begin
    if (core_interrupt_o === 1'b1) n_core_int <= n_core_int + 16'h0001;
  end

  // ==========
  // tasks
  // ==========
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cwr(input logic [15:0] w);
    @(negedge clk_sys_i);
    core_ctrl_wr_i    = 1'b1;
    core_ctrl_wdata_i = w;
    @(negedge clk_sys_i);
    core_ctrl_wr_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
  endtask

  task automatic hw(input logic [1:0] sel, input logic [15:0] w);
    u_host.wr16(sel, w, bo);
  endtask

  task automatic hr(input logic [1:0] sel, input logic [15:0] exp);
    logic [15:0] r;
    u_host.rd16(sel, bo, r);
    chk(r, exp);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs about 900 cycles
  initial begin
    #2ms;
    n_mismatch++;
    tally_and_finish();
  end

  // ==========
  // tests
  // ==========
  initial begin
    repeat (20) @(negedge clk_sys_i);
    chk({15'h0000, port_ready_o}, 16'h0001);
    chk(core_ctrl_rdata_o, CONTROL_RESET);
    rst_n_i = 1'b1;
    $display("test reset done");
    hw(SEL_CONTROL, 16'h0000);
    hr(SEL_CONTROL, 16'h0000);
    cwr(16'h0008);
    chk({15'h0000, host_interrupt_o}, 16'h0001);
    hr(SEL_CONTROL, 16'h0808);
    cwr(16'h0000);
    chk({15'h0000, host_interrupt_o}, 16'h0001);
    hw(SEL_CONTROL, 16'h0000);
    chk({15'h0000, host_interrupt_o}, 16'h0001);
    hw(SEL_CONTROL, 16'h0808);
    chk({15'h0000, host_interrupt_o}, 16'h0000);
    $display("test host flag done");
    cwr(16'h0004);
    chk(n_core_int, 16'h0000);
    hw(SEL_CONTROL, 16'h0404);
    hw(SEL_CONTROL, 16'h0404);
    chk(n_core_int, 16'h0002);
    hr(SEL_CONTROL, 16'h0000);
    $display("test core interrupt done");
    hw(SEL_CONTROL, 16'h0202);
    chk(core_ctrl_rdata_o, 16'h0000);
    cwr(16'h0202);
    chk(core_ctrl_rdata_o, 16'h0202);
    hr(SEL_CONTROL, 16'h0202);
    $display("test access mode done");
    hw(SEL_ADDRESS, 16'h0100);
    hw(SEL_DATA, 16'h1234);
    hr(SEL_DATA, 16'h1234);
    hw(SEL_ADDRESS, 16'h0100);
    hw(SEL_DATA_AI, 16'hC3A5);
    hr(SEL_ADDRESS, 16'h0101);
    hw(SEL_ADDRESS, 16'h0100);
    hr(SEL_DATA_AI, 16'h1234);
    hr(SEL_DATA_AI, 16'hC3A5);
    hw(SEL_ADDRESS, 16'h0901);
    hr(SEL_DATA, 16'hC3A5);
    hw(SEL_ADDRESS, 16'h07FF);
    hw(SEL_DATA_AI, 16'h0000);
    hr(SEL_ADDRESS, 16'h0800);
    $display("test memory done");
    bo = 1'b1;
    hw(SEL_CONTROL, 16'h0101);
    hr(SEL_CONTROL, 16'h0303);
    chk(core_ctrl_rdata_o, 16'h0202);
    hw(SEL_ADDRESS, 16'h0100);
    hr(SEL_DATA, 16'h1234);
    $display("test byte order done");
    tally_and_finish();
  end
endmodule
